// file: logic/usc_stall_cfg.sv
// endpoint stall control, setting capture and endpoint-1 receive dma request
`timescale 1ns/1ps
module usc_stall_cfg (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire usc_pkg::usc_axil_req_type axil_req_i,
	output usc_pkg::usc_axil_rsp_type axil_rsp_o,
	input wire logic setup_received_flag_i,
	input wire logic setup_decoded_i,
	input wire logic configuration_set_flag_i,
	input wire logic interface_set_flag_i,
	input wire usc_pkg::usc_setting_type setting_i,
	input wire usc_pkg::usc_token_type token_i,
	input wire logic ep1_rx_not_empty_i,
	input wire logic ep1_dma_all_read_i,
	output logic [usc_pkg::NUM_EP-1:0] stall_o,
	output logic stall_handshake_o,
	output logic receive_dma_request_line_o,
	output logic ep1_auto_read_o,
	output logic irq_o
);
	function automatic logic hit(input logic [usc_pkg::ADDR_W-1:0] addr,
			input logic [usc_pkg::ADDR_W-1:0] off);
		hit = (addr[usc_pkg::ADDR_W-1:2] == off[usc_pkg::ADDR_W-1:2]);
	endfunction

	// bus slave state
	logic aw_held;
	logic w_held;
	logic [usc_pkg::ADDR_W-1:0] wr_addr;
	logic [usc_pkg::DATA_W-1:0] wr_data;
	logic wr_lane0;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;

	// block state
	logic [usc_pkg::NUM_EP-1:0] stall;
	logic [usc_pkg::NUM_EP-1:0] next_stall;
	logic [7:0] settings;
	logic [7:0] next_settings;
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic endpoint1_dma_enable_bit;
	logic auto_clear_enable;

	// decode
	logic wr_stall;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_mapped;
	logic rd_status;
	logic rd_mapped;
	logic [7:0] rd_byte;
	logic [usc_pkg::NUM_EP-1:0] stall_wr_val;
	logic [usc_pkg::NUM_EP-1:0] token_hit;
	logic stall_answer;
	logic [usc_pkg::NUM_EP-1:0] auto_clear;
	logic cfg_rise;
	logic ifc_rise;
	logic [usc_pkg::NUM_EVT-1:0] events;
	logic [usc_pkg::NUM_EVT-1:0] evt_status;
	logic [usc_pkg::NUM_EVT-1:0] evt_mask;
	logic dma_done;

	assign aw_take = axil_req_i.awvalid & axil_rsp_o.awready;
	assign w_take = axil_req_i.wvalid & axil_rsp_o.wready;
	assign ar_take = axil_req_i.arvalid & axil_rsp_o.arready;
	assign do_write = aw_held & w_held & ~axil_rsp_o.bvalid;

	assign next_aw_held = do_write ? 1'b0 : (aw_take | aw_held);
	assign next_w_held = do_write ? 1'b0 : (w_take | w_held);
	assign next_bvalid = do_write | (axil_rsp_o.bvalid & ~axil_req_i.bready);
	assign next_rvalid = ar_take | (axil_rsp_o.rvalid & ~axil_req_i.rready);

	assign wr_stall = do_write & wr_lane0 & hit(wr_addr, usc_pkg::OFF_STALL);
	assign wr_ctrl = do_write & wr_lane0 & hit(wr_addr, usc_pkg::OFF_CTRL);
	assign wr_mask = do_write & wr_lane0 & hit(wr_addr, usc_pkg::OFF_MASK);
	// settings, status and flags are read only; writes answer okay and change nothing
	assign wr_mapped = hit(wr_addr, usc_pkg::OFF_STALL) | hit(wr_addr, usc_pkg::OFF_SETTINGS)
		| hit(wr_addr, usc_pkg::OFF_CTRL) | hit(wr_addr, usc_pkg::OFF_STATUS)
		| hit(wr_addr, usc_pkg::OFF_MASK) | hit(wr_addr, usc_pkg::OFF_FLAGS);
	assign rd_mapped = hit(axil_req_i.araddr, usc_pkg::OFF_STALL)
		| hit(axil_req_i.araddr, usc_pkg::OFF_SETTINGS)
		| hit(axil_req_i.araddr, usc_pkg::OFF_CTRL)
		| hit(axil_req_i.araddr, usc_pkg::OFF_STATUS)
		| hit(axil_req_i.araddr, usc_pkg::OFF_MASK)
		| hit(axil_req_i.araddr, usc_pkg::OFF_FLAGS);
	assign rd_status = ar_take & hit(axil_req_i.araddr, usc_pkg::OFF_STATUS);

	assign endpoint1_dma_enable_bit = ctrl[usc_pkg::CTRL_DMA_EN_BIT];
	assign auto_clear_enable = ctrl[usc_pkg::CTRL_AUTO_CLR_BIT];
	assign next_ctrl = wr_ctrl ? wr_data[1:0] : ctrl;

	// read data selection
	assign rd_byte =
		hit(axil_req_i.araddr, usc_pkg::OFF_STALL) ? {4'h0, stall} :
		hit(axil_req_i.araddr, usc_pkg::OFF_SETTINGS) ? settings :
		hit(axil_req_i.araddr, usc_pkg::OFF_CTRL) ? {6'h00, ctrl} :
		hit(axil_req_i.araddr, usc_pkg::OFF_STATUS) ? {3'h0, evt_status} :
		hit(axil_req_i.araddr, usc_pkg::OFF_MASK) ? {3'h0, evt_mask} :
		hit(axil_req_i.araddr, usc_pkg::OFF_FLAGS) ? {7'h00, setup_received_flag_i} :
		8'h00;

	// stall answer for the addressed endpoint
	assign token_hit = token_i.valid ? (4'h1 << token_i.endpoint) : 4'h0;
	assign stall_answer = |(token_hit & stall);

	// endpoint 0: software write, setup lockout, auto clear on decoded setup
	assign stall_wr_val[0] = (setup_received_flag_i & wr_data[0]) ? stall[0] : wr_data[0];
	assign auto_clear[0] = setup_decoded_i;
	assign next_stall[0] = auto_clear[0] ? 1'b0 : (wr_stall ? stall_wr_val[0] : stall[0]);

	// endpoints 1 to 3 hold until written or auto cleared after a stall answer
	genvar g;
	generate
		for (g = 1; g < usc_pkg::NUM_EP; g++) begin : gen_ep
			assign stall_wr_val[g] = wr_data[g];
			assign auto_clear[g] = auto_clear_enable & token_hit[g] & stall[g];
			assign next_stall[g] = wr_stall ? stall_wr_val[g] : (stall[g] & ~auto_clear[g]);
		end
	endgenerate

	// setting capture on flag rise
	usc_rise #(
		.W(2)
	) u_rise (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.level_i({configuration_set_flag_i, interface_set_flag_i}),
		.rise_o({cfg_rise, ifc_rise})
	);

	always_comb begin
		next_settings = settings;
		if (cfg_rise) begin
			next_settings[usc_pkg::CNF_LSB+:2] = setting_i.configuration_setting_field;
		end
		if (ifc_rise) begin
			next_settings[usc_pkg::INT_LSB+:2] = setting_i.interface_setting_field;
			next_settings[usc_pkg::ALT_LSB+:3] = setting_i.alternate_setting_field;
		end
		next_settings[usc_pkg::RSV_BIT] = 1'b0;
	end

	// completion of endpoint-1 dma read
	assign dma_done = endpoint1_dma_enable_bit & ep1_dma_all_read_i;

	assign events[usc_pkg::EVT_SETUP] = setup_decoded_i;
	assign events[usc_pkg::EVT_CONFIG] = cfg_rise;
	assign events[usc_pkg::EVT_IFACE] = ifc_rise;
	assign events[usc_pkg::EVT_STALL] = stall_answer;
	assign events[usc_pkg::EVT_DMA_DONE] = dma_done;

	usc_irq u_irq (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.event_i(events),
		.read_clear_i(rd_status),
		.mask_write_i(wr_mask),
		.mask_data_i(wr_data[usc_pkg::NUM_EVT-1:0]),
		.status_o(evt_status),
		.mask_o(evt_mask),
		.irq_o(irq_o)
	);

	// bus slave registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_lane0 <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_take) begin
				wr_addr <= axil_req_i.awaddr;
			end
			if (w_take) begin
				wr_data <= axil_req_i.wdata;
				wr_lane0 <= axil_req_i.wstrb[0];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			axil_rsp_o <= '0;
		end else begin
			axil_rsp_o.awready <= ~next_aw_held & ~next_bvalid;
			axil_rsp_o.wready <= ~next_w_held & ~next_bvalid;
			axil_rsp_o.bvalid <= next_bvalid;
			if (do_write) begin
				axil_rsp_o.bresp <= wr_mapped ? usc_pkg::RESP_OKAY : usc_pkg::RESP_SLVERR;
			end
			axil_rsp_o.arready <= ~next_rvalid;
			axil_rsp_o.rvalid <= next_rvalid;
			if (ar_take) begin
				axil_rsp_o.rdata <= {24'h000000, rd_byte};
				axil_rsp_o.rresp <= rd_mapped ? usc_pkg::RESP_OKAY : usc_pkg::RESP_SLVERR;
			end
		end
	end

	// block registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stall <= usc_pkg::STALL_RESET;
			settings <= usc_pkg::SETTINGS_RESET;
			ctrl <= usc_pkg::CTRL_RESET;
		end else begin
			stall <= next_stall;
			settings <= next_settings;
			ctrl <= next_ctrl;
		end
	end

	// outputs
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stall_o <= usc_pkg::STALL_RESET;
			stall_handshake_o <= 1'b0;
			receive_dma_request_line_o <= 1'b0;
			ep1_auto_read_o <= 1'b0;
		end else begin
			stall_o <= next_stall;
			stall_handshake_o <= stall_answer;
			receive_dma_request_line_o <= endpoint1_dma_enable_bit & ep1_rx_not_empty_i;
			ep1_auto_read_o <= dma_done;
		end
	end
endmodule

// file: logic/usc_pkg.sv
// shared constants and carriers for the endpoint stall and setting capture block
package usc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_EP = 4;
	localparam int NUM_EVT = 5;
	localparam logic [ADDR_W-1:0] OFF_STALL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SETTINGS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h14;
	localparam int CTRL_DMA_EN_BIT = 0;
	localparam int CTRL_AUTO_CLR_BIT = 1;
	localparam int EVT_SETUP = 0;
	localparam int EVT_CONFIG = 1;
	localparam int EVT_IFACE = 2;
	localparam int EVT_STALL = 3;
	localparam int EVT_DMA_DONE = 4;
	localparam int CNF_LSB = 6;
	localparam int INT_LSB = 4;
	localparam int RSV_BIT = 3;
	localparam int ALT_LSB = 0;
	localparam logic [NUM_EP-1:0] STALL_RESET = 4'h0;
	localparam logic [7:0] SETTINGS_RESET = 8'h00;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [NUM_EVT-1:0] EVT_RESET = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} usc_axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} usc_axil_rsp_type;

	typedef struct packed {
		logic [1:0] configuration_setting_field;
		logic [1:0] interface_setting_field;
		logic [2:0] alternate_setting_field;
	} usc_setting_type;

	typedef struct packed {
		logic valid;
		logic [1:0] endpoint;
	} usc_token_type;
endpackage

// file: logic/usc_rise.sv
// rising edge detector for a group of level flags
`timescale 1ns/1ps
module usc_rise #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] level_i,
	output logic [W-1:0] rise_o
);
	logic [W-1:0] level_prev;

	assign rise_o = level_i & ~level_prev;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_prev <= '0;
		end else begin
			level_prev <= level_i;
		end
	end
endmodule

// file: logic/usc_irq.sv
// sticky event status with read clear, mask and level interrupt
`timescale 1ns/1ps
module usc_irq (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [usc_pkg::NUM_EVT-1:0] event_i,
	input wire logic read_clear_i,
	input wire logic mask_write_i,
	input wire logic [usc_pkg::NUM_EVT-1:0] mask_data_i,
	output logic [usc_pkg::NUM_EVT-1:0] status_o,
	output logic [usc_pkg::NUM_EVT-1:0] mask_o,
	output logic irq_o
);
	logic [usc_pkg::NUM_EVT-1:0] next_status;
	logic [usc_pkg::NUM_EVT-1:0] next_mask;

	// a new event in the clearing cycle survives
	assign next_status = (read_clear_i ? '0 : status_o) | event_i;
	assign next_mask = mask_write_i ? mask_data_i : mask_o;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_o <= usc_pkg::EVT_RESET;
			mask_o <= usc_pkg::EVT_RESET;
			irq_o <= 1'b0;
		end else begin
			status_o <= next_status;
			mask_o <= next_mask;
			irq_o <= |(next_status & next_mask);
		end
	end
endmodule

// file: testbench/usc_host_model.sv
// host side model driving link events into the block
`timescale 1ns/1ps
module usc_host_model (
	input wire logic clock_i,
	output usc_pkg::usc_token_type token_o,
	output logic setup_decoded_o,
	output logic setup_received_o,
	output logic config_set_o,
	output logic iface_set_o,
	output usc_pkg::usc_setting_type setting_o,
	output logic rx_not_empty_o,
	output logic all_read_o
);
	initial begin
		token_o = '0;
		{setup_decoded_o, setup_received_o, config_set_o, iface_set_o} = 4'h0;
		setting_o = '0;
		{rx_not_empty_o, all_read_o} = 2'h0;
	end
	task tok(input logic [1:0] ep);
		token_o <= '{1'b1, ep};
		@(posedge clock_i);
		token_o.valid <= 1'b0;
	endtask
	task setup();
		setup_decoded_o <= 1'b1;
		@(posedge clock_i);
		setup_decoded_o <= 1'b0;
	endtask
	// setting valid only with a flag, scrambled after
	task flag(input logic c, input logic i, input usc_pkg::usc_setting_type s);
		config_set_o <= c;
		iface_set_o <= i;
		setting_o <= s;
		repeat (2) @(posedge clock_i);
		{config_set_o, iface_set_o} <= 2'h0;
		setting_o <= ~s;
	endtask
	task lvl(input logic sr, input logic ne);
		setup_received_o <= sr;
		rx_not_empty_o <= ne;
	endtask
	task done();
		all_read_o <= 1'b1;
		@(posedge clock_i);
		all_read_o <= 1'b0;
	endtask
endmodule

// file: testbench/usc_stall_cfg_chk.sv
// assertion checker for the stall and setting capture block
`timescale 1ns/1ps
module usc_stall_cfg_chk (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire usc_pkg::usc_axil_req_type axil_req_i,
	input wire usc_pkg::usc_axil_rsp_type axil_rsp_o,
	input wire logic setup_received_flag_i,
	input wire logic setup_decoded_i,
	input wire usc_pkg::usc_token_type token_i,
	input wire logic ep1_rx_not_empty_i,
	input wire logic ep1_dma_all_read_i,
	input wire logic [usc_pkg::NUM_EP-1:0] stall_o,
	input wire logic stall_handshake_o,
	input wire logic receive_dma_request_line_o,
	input wire logic ep1_auto_read_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic [usc_pkg::ADDR_W-1:0] rd_addr;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) rd_addr <= 8'h00;
		else if (axil_req_i.arvalid && axil_rsp_o.arready) rd_addr <= axil_req_i.araddr;
	end
	a_stall_answer: assert property (token_i.valid && stall_o[token_i.endpoint]
		|=> stall_handshake_o) else $error("stall handshake missing");
	a_no_handshake: assert property (!(token_i.valid && stall_o[token_i.endpoint])
		|=> !stall_handshake_o) else $error("stall handshake unexpected");
	a_setup_clear: assert property (setup_decoded_i |=> !stall_o[0])
		else $error("ep0 stall not cleared");
	a_setup_block: assert property (setup_received_flag_i && !stall_o[0] |=> !stall_o[0])
		else $error("ep0 stall set while blocked");
	a_dma_request: assert property (receive_dma_request_line_o |-> $past(ep1_rx_not_empty_i))
		else $error("dma request without data");
	a_auto_read: assert property (ep1_auto_read_o |-> $past(ep1_dma_all_read_i))
		else $error("auto read without completion");
	a_stall_held: assert property (stall_o[3:1] != $past(stall_o[3:1]) |-> axil_rsp_o.bvalid
		|| $past(token_i.valid) || $past(token_i.valid, 2)) else $error("stall bits changed");
	a_stall_upper: assert property (axil_rsp_o.rvalid && rd_addr == usc_pkg::OFF_STALL
		|-> axil_rsp_o.rdata[31:4] == 28'h0) else $error("stall upper bits set");
	a_rsvd_bit: assert property (axil_rsp_o.rvalid && rd_addr == usc_pkg::OFF_SETTINGS
		|-> !axil_rsp_o.rdata[usc_pkg::RSV_BIT]) else $error("reserved bit set");
endmodule
bind usc_stall_cfg usc_stall_cfg_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o), .setup_decoded_i(setup_decoded_i),
	.setup_received_flag_i(setup_received_flag_i), .token_i(token_i), .stall_o(stall_o),
	.ep1_rx_not_empty_i(ep1_rx_not_empty_i), .ep1_dma_all_read_i(ep1_dma_all_read_i),
	.stall_handshake_o(stall_handshake_o), .ep1_auto_read_o(ep1_auto_read_o),
	.receive_dma_request_line_o(receive_dma_request_line_o));

// file: testbench/usc_stall_cfg_test.sv
// self-checking bench for the stall and setting capture block
`timescale 1ns/1ps
module usc_stall_cfg_test;
	logic clock_i;
	logic rst_n_i;
	usc_pkg::usc_axil_req_type req;
	usc_pkg::usc_axil_rsp_type rsp;
	usc_pkg::usc_token_type tok;
	usc_pkg::usc_setting_type set;
	logic sdec, srec, cfs, ifs, ne, ar, hs, dreq, aread, irq;
	logic [3:0] stall;
	logic [31:0] d;
	logic [1:0] r;
	logic [1:0] b;
	int miscompares;
	int cmp_count;
	usc_stall_cfg i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .axil_req_i(req),
		.axil_rsp_o(rsp), .setup_received_flag_i(srec), .setup_decoded_i(sdec),
		.configuration_set_flag_i(cfs), .interface_set_flag_i(ifs), .setting_i(set),
		.token_i(tok), .ep1_rx_not_empty_i(ne), .ep1_dma_all_read_i(ar), .stall_o(stall),
		.stall_handshake_o(hs), .receive_dma_request_line_o(dreq), .ep1_auto_read_o(aread),
		.irq_o(irq));
	usc_host_model i_host (.clock_i(clock_i), .token_o(tok), .setup_decoded_o(sdec),
		.setup_received_o(srec), .config_set_o(cfs), .iface_set_o(ifs), .setting_o(set),
		.rx_not_empty_o(ne), .all_read_o(ar));
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	task report_and_stop();
		if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		req.awaddr <= a;
		req.wdata <= v;
		{req.awvalid, req.wvalid} <= 2'h3;
		do begin
			@(posedge clock_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		b = rsp.bresp;
	endtask
	task rd(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do begin
			@(posedge clock_i);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
		chk("rresp", usc_pkg::RESP_OKAY, r);
	endtask
	initial begin
		req = '0;
		{req.bready, req.rready, req.wstrb} = 6'h3f;
		rst_n_i = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rchk("stall", usc_pkg::OFF_STALL, 0);
		rchk("settings", usc_pkg::OFF_SETTINGS, 0);
		wr(usc_pkg::OFF_MASK, 1);
		i_host.setup();
		repeat (2) @(posedge clock_i);
		chk("irq", 1, irq);
		rchk("status", usc_pkg::OFF_STATUS, 1);
		@(posedge clock_i);
		chk("irq", 0, irq);
		rd(8'h3c);
		chk("unmapped rresp", usc_pkg::RESP_SLVERR, r);
		wr(8'h3c, 32'h0);
		chk("unmapped bresp", usc_pkg::RESP_SLVERR, b);
		wr(usc_pkg::OFF_STALL, 32'h0f);
		chk("bresp", usc_pkg::RESP_OKAY, b);
		rchk("stall", usc_pkg::OFF_STALL, 32'h0f);
		for (int e = 0; e < 4; e++) begin
			i_host.tok(e[1:0]);
			@(posedge clock_i);
			chk("handshake", 1, hs);
		end
		i_host.setup();
		rchk("stall", usc_pkg::OFF_STALL, 32'h0e);
		i_host.lvl(1'b1, 1'b0);
		rchk("flags", usc_pkg::OFF_FLAGS, 1);
		wr(usc_pkg::OFF_STALL, 32'h0f);
		rchk("stall", usc_pkg::OFF_STALL, 32'h0e);
		i_host.lvl(1'b0, 1'b0);
		wr(usc_pkg::OFF_STALL, 0);
		rchk("stall", usc_pkg::OFF_STALL, 0);
		req.wstrb <= 4'he;
		wr(usc_pkg::OFF_STALL, 32'h0f);
		req.wstrb <= 4'hf;
		chk("bresp", usc_pkg::RESP_OKAY, b);
		rchk("stall", usc_pkg::OFF_STALL, 0);
		i_host.tok(2'h1);
		@(posedge clock_i);
		chk("handshake", 0, hs);
		i_host.flag(1'b1, 1'b0, '{2'h2, 2'h1, 3'h5});
		rchk("settings", usc_pkg::OFF_SETTINGS, 32'h2 << usc_pkg::CNF_LSB);
		i_host.flag(1'b0, 1'b1, '{2'h1, 2'h3, 3'h7});
		d = (32'h2 << usc_pkg::CNF_LSB) | (32'h3 << usc_pkg::INT_LSB) | 32'h7;
		rchk("settings", usc_pkg::OFF_SETTINGS, d);
		wr(usc_pkg::OFF_SETTINGS, 32'hf7);
		chk("bresp", usc_pkg::RESP_OKAY, b);
		rchk("settings", usc_pkg::OFF_SETTINGS, 32'hb7);
		wr(usc_pkg::OFF_CTRL, 32'h2);
		wr(usc_pkg::OFF_STALL, 32'h4);
		i_host.tok(2'h2);
		@(posedge clock_i);
		chk("handshake", 1, hs);
		rchk("stall", usc_pkg::OFF_STALL, 0);
		i_host.lvl(1'b0, 1'b1);
		repeat (2) @(posedge clock_i);
		chk("dma request", 0, dreq);
		wr(usc_pkg::OFF_CTRL, 32'h1);
		rchk("ctrl", usc_pkg::OFF_CTRL, 1);
		repeat (2) @(posedge clock_i);
		chk("dma request", 1, dreq);
		i_host.done();
		@(posedge clock_i);
		chk("auto read", 1, aread);
		i_host.lvl(1'b0, 1'b0);
		repeat (2) @(posedge clock_i);
		chk("dma request", 0, dreq);
		rchk("status", usc_pkg::OFF_STATUS, 32'h1f);
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		miscompares++;
		report_and_stop();
	end
endmodule
